// File: hw/dpfa_core.sv
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
// Function
// RULE1: Add magnitude normalized, within eleven L cycles
// RULE2: Add magnitude unnormalized, within eight L cycles
// RULE3: Subtract normalized, within eleven L cycles
// RULE4: Subtract unnormalized, within eight L cycles
// RULE5: Subtract magnitude normalized, within eleven L cycles
// RULE6: Subtract magnitude unnormalized, within eight L cycles
// RULE7: Every operation can flag characteristic overflow, underflow
// RULE8: Multiply high part main, low part low-order
// RULE9: Three partial products, low times low omitted
// RULE10: Zero pair test ends at execute time
// RULE11: Product signs set algebraically during execute time
// RULE12: State 0 first multiply, then swap
// RULE13: State 1 second multiply, add, carry steps twice
// RULE14: Third multiply in state 2 or 3
// RULE15: Cross products high halves added to low half
// RULE16: Unnormal product shifts left, characteristic minus one
// RULE17: Zero product clears both characteristics
// RULE18: Characteristic sum minus 200 octal, low minus 27
// RULE19: Final step sets low characteristic, tests zero
// RULE20: Shift counter loads octal 33, 14 pulses
// RULE21: Multiply starts and ends at fixed pulses
// RULE22: Low-order sign equal, characteristic minus 27
// RULE23: Scratch register overwritten by every operation
// RULE24: Unlike signs use two's complement addition
// RULE25: Far apart operands end early with larger
// RULE26: Sign bit 0, characteristic 1-8, fraction 9-35
// RULE27: Characteristic outside eight bits flags overflow/underflow
module dpfa_core (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Operation status
  output logic             opBusy
);

  // Architectural registers, bit 0 most significant
  logic [0:35]  ac;          // Main result register
  logic [0:35]  mq;          // Low-order register
  logic [0:35]  sr;          // Storage operand register, first word
  logic [0:35]  ibr;         // Second word, fraction used only
  logic [0:35]  si;          // Scratch register
  // Control and status
  logic [8:0]   opCode;      // Opcode magnitude
  logic         opMinus;     // Minus form, no normalization
  logic         opDone;      // Finished flag
  logic         flagOvf;     // Characteristic overflow
  logic         flagUnf;     // Characteristic underflow
  logic         flagIll;     // Unsupported opcode seen
  logic [1:0]   double_step_sequencer;         // Double step sequencer
  dpfa_pkg::dpfa_state_e state;  // Sequencer state
  logic [6:0]   tick;        // Pulse count since start
  // Work registers
  logic         wSign;       // Result sign
  logic [10:0]  wChar;       // Result characteristic, two's complement
  logic [53:0]  wFrac;       // Result double fraction
  logic [53:0]  wAddend;     // Aligned smaller fraction
  logic         wUnlike;     // Operand signs differ
  // Multiplier
  logic [4:0]   sc;          // Shift counter
  logic [55:0]  prod;        // Partial product and multiplier
  logic [26:0]  mcand;       // Multiplicand
  // Bus pipeline
  logic         wrPend;      // Write data phase pending
  logic [7:0]   wrAddr;      // Captured write offset

  // Field views of the operands
  wire logic [26:0] fracA = ac[dpfa_pkg::FRAC_MSB:dpfa_pkg::FRAC_LSB];
  wire logic [26:0] fracB = mq[dpfa_pkg::FRAC_MSB:dpfa_pkg::FRAC_LSB];
  wire logic [26:0] fracC = sr[dpfa_pkg::FRAC_MSB:dpfa_pkg::FRAC_LSB];
  wire logic [26:0] fracD = ibr[dpfa_pkg::FRAC_MSB:dpfa_pkg::FRAC_LSB];
  wire logic [26:0] siFrac = si[dpfa_pkg::FRAC_MSB:dpfa_pkg::FRAC_LSB];
  wire logic [7:0]  charN = ac[dpfa_pkg::CHAR_MSB:dpfa_pkg::CHAR_LSB];
  wire logic [7:0]  charM = sr[dpfa_pkg::CHAR_MSB:dpfa_pkg::CHAR_LSB];
  wire logic [53:0] accFrac = {fracA, fracB};  // see RULE26
  wire logic [53:0] memFrac = {fracC, fracD};

  // Bus decode
  wire logic addrPhase = hsel && htrans[1] && hready;
  wire logic busWrite  = wrPend && (state == dpfa_pkg::ST_IDLE);
  wire logic ctrlWrite = busWrite && (wrAddr == dpfa_pkg::ADDR_CTRL);
  wire logic startReq  = ctrlWrite && hwdata[dpfa_pkg::CTRL_START_BIT];
  wire logic [8:0] newCode = hwdata[8:0];
  wire logic newMinus = hwdata[dpfa_pkg::CTRL_MINUS_BIT];
  wire logic newIsAdd = (newCode == dpfa_pkg::OP_ADD_MAG) ||
                        (newCode == dpfa_pkg::OP_SUB) ||
                        (newCode == dpfa_pkg::OP_SUB_MAG);
  wire logic newIsMul = (newCode == dpfa_pkg::OP_MUL) && !newMinus;
  wire logic newLegal = newIsAdd || newIsMul;

  // Operation decode
  wire logic isMul   = (opCode == dpfa_pkg::OP_MUL);
  wire logic normOn  = !opMinus;
  logic      ySign;  // Effective sign of the storage operand

  // Storage operand sign per operation
  always_comb begin
    case (opCode)
      dpfa_pkg::OP_ADD_MAG: ySign = 1'b0;    // see RULE1
      dpfa_pkg::OP_SUB:     ySign = ~sr[0];  // see RULE3, RULE4
      dpfa_pkg::OP_SUB_MAG: ySign = 1'b1;    // see RULE5, RULE6
      default:              ySign = sr[0];
    endcase
  end

  // Alignment of the two add operands
  wire logic        accBig    = charN >= charM;
  wire logic        bigSign   = accBig ? ac[0] : ySign;
  wire logic [7:0]  bigChar   = accBig ? charN : charM;
  wire logic [7:0]  smallChar = accBig ? charM : charN;
  wire logic [53:0] bigFrac   = accBig ? accFrac : memFrac;
  wire logic [53:0] smallFrac = accBig ? memFrac : accFrac;
  wire logic [7:0]  charDiff  = bigChar - smallChar;
  wire logic        farApart  = charDiff > dpfa_pkg::DIFF_LIMIT;
  wire logic [53:0] aligned   = farApart ? 54'h0 :
                                smallFrac >> charDiff[5:0];
  wire logic        earlyEnd  = farApart && bigFrac[53];

  // Fraction adders
  wire logic [54:0] likeSum = {1'b0, wFrac} + {1'b0, wAddend};
  wire logic [54:0] cmpSum  = {1'b0, wFrac} + {1'b0, ~wAddend} + 55'h1;
  wire logic [53:0] negFrac = (~cmpSum[53:0]) + 54'h1;

  // Radix-4 multiply step
  logic [29:0] mpyAddend;  // Multiplicand times two multiplier bits
  always_comb begin
    case (prod[1:0])
      2'h0:    mpyAddend = 30'h0;
      2'h1:    mpyAddend = {3'h0, mcand};
      2'h2:    mpyAddend = {2'h0, mcand, 1'b0};
      default: mpyAddend = {3'h0, mcand} + {2'h0, mcand, 1'b0};
    endcase
  end
  wire logic [29:0] mpyUpper = {2'h0, prod[55:28]} + mpyAddend;
  wire logic [55:0] nextProd = {mpyUpper, prod[27:2]};

  // Multiply load points and operand steering
  wire logic mpyLoad1 = (state == dpfa_pkg::ST_EXEC) && isMul &&
                        (tick == dpfa_pkg::MPY1_START);
  wire logic mpyLoad2 = (state == dpfa_pkg::ST_MPY) &&
                        (tick == dpfa_pkg::MPY2_START);
  wire logic mpyLoad3 = (state == dpfa_pkg::ST_MPY) &&
                        (tick == dpfa_pkg::MPY3_START);
  wire logic [26:0] mplierSel = mpyLoad1 ? fracB : fracA;
  wire logic [26:0] mcandSel  = mpyLoad2 ? fracD : fracC;  // see RULE9

  // Partial product sums
  wire logic [27:0] crossSum = {1'b0, siFrac} + {1'b0, nextProd[53:27]};
  wire logic [53:0] carryIn  = {26'h0, (double_step_sequencer == 2'h3), 27'h0};
  wire logic [53:0] finSum   = nextProd[53:0] + {27'h0, siFrac} + carryIn;

  // Execute-time zero pair test
  wire logic zeroA = (fracA == 27'h0);
  wire logic zeroB = (fracB == 27'h0);
  wire logic zeroC = (fracC == 27'h0);
  wire logic zeroD = (fracD == 27'h0);
  wire logic zeroPair = (zeroA && zeroB) || (zeroC && zeroD) ||
                        (zeroA && zeroC);
  wire logic [10:0] mulChar = {3'h0, charN} + {3'h0, charM} -
                              dpfa_pkg::CHAR_BIAS;

  // Final characteristics and range checks
  wire logic [10:0] mqChar   = wChar - dpfa_pkg::MQ_CHAR_OFS;
  wire logic        fracZero = (wFrac == 54'h0);
  wire logic        clearChr = fracZero && (isMul || normOn);
  wire logic        charOver = !wChar[10] && (wChar[9:8] != 2'h0);
  wire logic        charUnder = wChar[10] || mqChar[10];

  // Register read selection
  logic [31:0] readWord;
  always_comb begin
    readWord = 32'h0;
    case (haddr[7:0])
      dpfa_pkg::ADDR_CTRL:   readWord = {22'h0, opMinus, opCode};
      dpfa_pkg::ADDR_STATUS: begin
        readWord[dpfa_pkg::ST_BUSY_BIT] = opBusy;
        readWord[dpfa_pkg::ST_DONE_BIT] = opDone;
        readWord[dpfa_pkg::ST_OVF_BIT]  = flagOvf;
        readWord[dpfa_pkg::ST_UNF_BIT]  = flagUnf;
        readWord[dpfa_pkg::ST_ILL_BIT]  = flagIll;
        readWord[dpfa_pkg::ST_DPS_LSB +: 2] = double_step_sequencer;
      end
      dpfa_pkg::ADDR_AC_HI:  readWord = {23'h0, ac[0:8]};
      dpfa_pkg::ADDR_AC_FR:  readWord = {5'h0, fracA};
      dpfa_pkg::ADDR_MQ_HI:  readWord = {23'h0, mq[0:8]};
      dpfa_pkg::ADDR_MQ_FR:  readWord = {5'h0, fracB};
      dpfa_pkg::ADDR_Y_HI:   readWord = {23'h0, sr[0:8]};
      dpfa_pkg::ADDR_Y_FR:   readWord = {5'h0, fracC};
      dpfa_pkg::ADDR_Y1_FR:  readWord = {5'h0, fracD};
      dpfa_pkg::ADDR_SI_HI:  readWord = {23'h0, si[0:8]};
      dpfa_pkg::ADDR_SI_FR:  readWord = {5'h0, siFrac};
      default:               readWord = 32'h0;
    endcase
  end

  // Bus slave: zero wait states, reads registered at address phase
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0;
      wrPend    <= 1'b0;
      wrAddr    <= 8'h0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      // Only word writes are taken
      wrPend    <= addrPhase && hwrite && (hsize == 3'h2);
      wrAddr    <= haddr[7:0];
      if (addrPhase && !hwrite) begin
        hrdata <= readWord;
      end
    end
  end

  // Fraction multiplier, two bits per pulse
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sc    <= 5'h0;
      prod  <= 56'h0;
      mcand <= 27'h0;
    end else if (mpyLoad1 || mpyLoad2 || mpyLoad3) begin  // see RULE21
      sc    <= dpfa_pkg::SC_LOAD;  // see RULE20
      prod  <= {29'h0, mplierSel};
      mcand <= mcandSel;
    end else if (sc != 5'h0) begin
      // Steps down to zero in 14 pulses
      sc   <= (sc > dpfa_pkg::SC_STEP) ? sc - dpfa_pkg::SC_STEP
                                       : 5'h0;  // see RULE20
      prod <= nextProd;
    end
  end

  // Operation sequencer and register file
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ac      <= 36'h0;
      mq      <= 36'h0;
      sr      <= 36'h0;
      ibr     <= 36'h0;
      si      <= 36'h0;
      opCode  <= 9'h0;
      opMinus <= 1'b0;
      opBusy  <= 1'b0;
      opDone  <= 1'b0;
      flagOvf <= 1'b0;
      flagUnf <= 1'b0;
      flagIll <= 1'b0;
      double_step_sequencer     <= 2'h0;
      state   <= dpfa_pkg::ST_IDLE;
      tick    <= 7'h0;
      wSign   <= 1'b0;
      wChar   <= 11'h0;
      wFrac   <= 54'h0;
      wAddend <= 54'h0;
      wUnlike <= 1'b0;
    end else begin
      tick <= opBusy ? tick + 7'h1 : 7'h0;
      case (state)
        dpfa_pkg::ST_IDLE: begin
          // Software loads operands only while idle
          if (busWrite) begin
            case (wrAddr)
              dpfa_pkg::ADDR_AC_HI: ac[0:8]  <= hwdata[8:0];
              dpfa_pkg::ADDR_AC_FR: ac[9:35] <= hwdata[26:0];
              dpfa_pkg::ADDR_MQ_HI: mq[0:8]  <= hwdata[8:0];
              dpfa_pkg::ADDR_MQ_FR: mq[9:35] <= hwdata[26:0];
              dpfa_pkg::ADDR_Y_HI:  sr[0:8]  <= hwdata[8:0];
              dpfa_pkg::ADDR_Y_FR:  sr[9:35] <= hwdata[26:0];
              dpfa_pkg::ADDR_Y1_FR: ibr[9:35] <= hwdata[26:0];
              dpfa_pkg::ADDR_CTRL: begin
                opCode  <= newCode;
                opMinus <= newMinus;
              end
              default: ;
            endcase
          end
          // Start a legal operation or flag the opcode
          if (startReq) begin
            opDone  <= !newLegal;
            flagIll <= !newLegal;
            flagOvf <= 1'b0;
            flagUnf <= 1'b0;
            opBusy  <= newLegal;
            double_step_sequencer     <= 2'h0;
            state   <= newLegal ? dpfa_pkg::ST_EXEC : dpfa_pkg::ST_IDLE;
          end
        end
        dpfa_pkg::ST_EXEC: begin
          if (tick == dpfa_pkg::E_END) begin
            if (isMul) begin
              // Signs fixed now whether or not multiply runs
              wSign <= ac[0] ^ sr[0];  // see RULE11
              wChar <= mulChar;        // see RULE18
              si    <= sr;             // see RULE23
              if (zeroPair) begin
                // Zero pair: end with signed normal zero
                wFrac <= 54'h0;        // see RULE10
                state <= dpfa_pkg::ST_FINAL;
              end else begin
                state <= dpfa_pkg::ST_MPY;
              end
            end else begin
              // Larger operand kept in scratch
              si      <= {bigSign, bigChar, bigFrac[53:27]};  // see RULE23
              wSign   <= bigSign;
              wChar   <= {3'h0, bigChar};
              wFrac   <= bigFrac;
              wAddend <= aligned;
              wUnlike <= ac[0] ^ ySign;
              // Far apart with normal larger: it is the result
              state   <= earlyEnd ? dpfa_pkg::ST_FINAL
                                  : dpfa_pkg::ST_ADD;  // see RULE25
            end
          end
        end
        dpfa_pkg::ST_ADD: begin
          double_step_sequencer <= 2'h1;
          if (!wUnlike) begin
            // True add, carry shifts right one place
            wFrac <= likeSum[54] ? likeSum[54:1] : likeSum[53:0];
            wChar <= wChar + {10'h0, likeSum[54]};
          end else if (cmpSum[54]) begin
            // Two's complement add, result already true
            wFrac <= cmpSum[53:0];  // see RULE24
          end else begin
            // No carry: recomplement and take the other sign
            wFrac <= negFrac;  // see RULE24
            wSign <= ~wSign;
          end
          state <= normOn ? dpfa_pkg::ST_NORM
                          : dpfa_pkg::ST_FINAL;  // see RULE2
        end
        dpfa_pkg::ST_NORM: begin
          // One place a pulse until the top bit is set
          if (fracZero || wFrac[53]) begin
            state <= dpfa_pkg::ST_FINAL;  // see RULE1
          end else begin
            wFrac <= {wFrac[52:0], 1'b0};
            wChar <= wChar - 11'h1;
          end
        end
        dpfa_pkg::ST_MPY: begin
          if (tick == dpfa_pkg::MPY1_END) begin
            // State 0: keep high half of B times C, swap
            si[9:35] <= nextProd[53:27];  // see RULE12
            double_step_sequencer      <= 2'h1;
          end else if (tick == dpfa_pkg::MPY2_END) begin
            // State 1: sum cross products, carry steps twice
            si[9:35] <= crossSum[26:0];   // see RULE15
            double_step_sequencer      <= crossSum[27] ? 2'h3 : 2'h2;  // see RULE13
          end else if (tick == dpfa_pkg::MPY3_END) begin
            // State 2 or 3: high product plus cross sum
            wFrac <= finSum;  // see RULE14
            state <= dpfa_pkg::ST_MFIX;
          end
        end
        dpfa_pkg::ST_MFIX: begin
          // Single left shift for an unnormal product
          if (!fracZero && !wFrac[53]) begin
            wFrac <= {wFrac[52:0], 1'b0};  // see RULE16
            wChar <= wChar - 11'h1;
          end
          state <= dpfa_pkg::ST_FINAL;
        end
        dpfa_pkg::ST_FINAL: begin
          // Write back: high part main, low part low-order
          ac[0]    <= wSign;           // see RULE8
          mq[0]    <= wSign;           // see RULE22
          ac[9:35] <= wFrac[53:27];
          mq[9:35] <= wFrac[26:0];
          if (clearChr) begin
            ac[1:8] <= 8'h0;           // see RULE17
            mq[1:8] <= 8'h0;
          end else begin
            ac[1:8] <= wChar[7:0];
            mq[1:8] <= mqChar[7:0];    // see RULE19
            flagOvf <= charOver;       // see RULE27
            flagUnf <= charUnder;      // see RULE7
          end
          opBusy <= 1'b0;
          opDone <= 1'b1;
          state  <= dpfa_pkg::ST_IDLE;
        end
        default: state <= dpfa_pkg::ST_IDLE;
      endcase
    end
  end

endmodule // dpfa_core

// File: hw/dpfa_pkg.sv
// Shared constants for the double-precision add and multiply datapath
package dpfa_pkg;

  // Word layout: bit 0 is the most significant bit of a 36-bit word
  localparam int WORD_W    = 36;  // Machine word width
  localparam int FRAC_W    = 27;  // Single fraction width
  localparam int DFRAC_W   = 54;  // Double fraction width
  localparam int SIGN_POS  = 0;   // Sign bit position
  localparam int CHAR_MSB  = 1;   // Characteristic first bit
  localparam int CHAR_LSB  = 8;   // Characteristic last bit
  localparam int FRAC_MSB  = 9;   // Fraction first bit
  localparam int FRAC_LSB  = 35;  // Fraction last bit

  // Operation codes, magnitude part (octal 0305, 0303, 0307, 0261)
  localparam logic [8:0] OP_ADD_MAG = 9'h0C5;  // Add magnitude
  localparam logic [8:0] OP_SUB     = 9'h0C3;  // Subtract
  localparam logic [8:0] OP_SUB_MAG = 9'h0C7;  // Subtract magnitude
  localparam logic [8:0] OP_MUL     = 9'h0B1;  // Double multiply

  // Register byte offsets on the bus
  localparam logic [7:0] ADDR_CTRL   = 8'h00;  // Opcode and start
  localparam logic [7:0] ADDR_STATUS = 8'h04;  // Busy, done, flags
  localparam logic [7:0] ADDR_AC_HI  = 8'h08;  // Main result sign+char
  localparam logic [7:0] ADDR_AC_FR  = 8'h0C;  // Main result fraction
  localparam logic [7:0] ADDR_MQ_HI  = 8'h10;  // Low-order sign+char
  localparam logic [7:0] ADDR_MQ_FR  = 8'h14;  // Low-order fraction
  localparam logic [7:0] ADDR_Y_HI   = 8'h18;  // Storage operand sign+char
  localparam logic [7:0] ADDR_Y_FR   = 8'h1C;  // Storage operand fraction
  localparam logic [7:0] ADDR_Y1_FR  = 8'h20;  // Second word fraction
  localparam logic [7:0] ADDR_SI_HI  = 8'h24;  // Scratch sign+char
  localparam logic [7:0] ADDR_SI_FR  = 8'h28;  // Scratch fraction

  // Control and status bit positions
  localparam int CTRL_MINUS_BIT = 9;   // Minus form of the opcode
  localparam int CTRL_START_BIT = 31;  // Start request
  localparam int ST_BUSY_BIT    = 0;   // Operation running
  localparam int ST_DONE_BIT    = 1;   // Operation finished
  localparam int ST_OVF_BIT     = 2;   // Characteristic overflow
  localparam int ST_UNF_BIT     = 3;   // Characteristic underflow
  localparam int ST_ILL_BIT     = 4;   // Unsupported opcode
  localparam int ST_DPS_LSB     = 8;   // Sequencer state, two bits

  // Machine pulse timing: E cycle is cycle 0, then L1, L2 ...
  localparam int PULSES_PER_CYCLE = 8;
  localparam logic [6:0] E_END      = 7'(0 * PULSES_PER_CYCLE + 7);
  localparam logic [6:0] MPY1_START = 7'(0 * PULSES_PER_CYCLE + 6);
  localparam logic [6:0] MPY1_END   = 7'(2 * PULSES_PER_CYCLE + 4);
  localparam logic [6:0] MPY2_START = 7'(3 * PULSES_PER_CYCLE + 3);
  localparam logic [6:0] MPY2_END   = 7'(5 * PULSES_PER_CYCLE + 1);
  localparam logic [6:0] MPY3_START = 7'(5 * PULSES_PER_CYCLE + 7);
  localparam logic [6:0] MPY3_END   = 7'(7 * PULSES_PER_CYCLE + 5);

  // Arithmetic constants
  localparam logic [4:0]  SC_LOAD      = 5'h1B;   // Octal 33 bit count
  localparam logic [4:0]  SC_STEP      = 5'h02;   // Bits retired a pulse
  localparam logic [10:0] CHAR_BIAS    = 11'h080; // Octal 200
  localparam logic [10:0] MQ_CHAR_OFS  = 11'h01B; // Decimal 27
  localparam logic [7:0]  DIFF_LIMIT   = 8'h3F;   // Octal 77

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_EXEC, ST_ADD, ST_NORM, ST_MPY, ST_MFIX, ST_FINAL
  } dpfa_state_e;

endpackage

// File: bench/dpfa_mem_model.sv
`timescale 1ns/10ps
// Core memory pair holding the addressed operand
module dpfa_mem_model (
  // Operand fields set by the bench
  input  wire logic        ySign,
  input  wire logic [7:0]  yChar,
  input  wire logic [26:0] yHiFrac,
  input  wire logic [26:0] yLoFrac,
  // Stored words
  output logic [35:0]      yWord,
  output logic [35:0]      y1Word
);
  // Sign on top, then characteristic, then fraction
  assign yWord  = {ySign, yChar, yHiFrac};
  // Second word keeps the sign, characteristic 27 lower
  assign y1Word = {ySign, yChar - 8'h1B, yLoFrac};
endmodule // dpfa_mem_model

// File: bench/dpfa_core_chk.sv
`timescale 1ns/10ps
// Watches start requests, busy length and read data hold
module dpfa_core_chk (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  // Bus requests
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  // Bus answers and status
  input wire logic [31:0] hrdata,
  input wire logic        opBusy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic       ctrlWr;                          // Control data phase
  wire  logic take = hsel & htrans[1] & hready;  // Address phase
  wire  logic [8:0] opc = hwdata[8:0];          // Opcode field
  wire  logic go = ctrlWr & hwdata[31] & !opBusy;  // Start while idle
  wire  logic isMul = opc == dpfa_pkg::OP_MUL;  // Multiply code
  wire  logic isAdd = opc == dpfa_pkg::OP_ADD_MAG | opc == dpfa_pkg::OP_SUB
                    | opc == dpfa_pkg::OP_SUB_MAG;  // Add family codes
  // Remember control-register write address phases
  always_ff @(posedge sys_clk) begin
    if (sys_rst) ctrlWr <= 1'b0;
    else ctrlWr <= take & hwrite & (haddr[7:0] == dpfa_pkg::ADDR_CTRL);
  end
  mul_start_a: assert property (go && !hwdata[9] && isMul |=> opBusy)
    else $error("multiply start did not raise busy");
  minus_mul_a: assert property (go && hwdata[9] && isMul |=> !opBusy)
    else $error("minus multiply was run");
  mul_len_a: assert property (go && !hwdata[9] && isMul |-> ##[9:65] !opBusy)
    else $error("multiply ran too long");
  unorm_len_a: assert property (go && hwdata[9] && isAdd |-> ##[9:73] !opBusy)
    else $error("unnormalized add ran too long");
  norm_len_a: assert property (go && !hwdata[9] && isAdd |-> ##[9:97] !opBusy)
    else $error("normalized add ran too long");
  busy_min_a: assert property ($rose(opBusy) |-> opBusy[*8])
    else $error("operation shorter than execute time");
  idle_stay_a: assert property (!opBusy && !go |=> !opBusy)
    else $error("busy without a start");
  rdata_hold_a: assert property (!(take && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");
endmodule // dpfa_core_chk

bind dpfa_core dpfa_core_chk chk_u (.sys_clk, .sys_rst, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hwdata, .hrdata, .opBusy);

// File: bench/dpfa_core_tb_top.sv
`timescale 1ns/10ps
// Self-checking bench for the double-precision datapath
module dpfa_core_tb_top;
  logic        sys_clk, sys_rst, hsel, hwrite, hreadyout, hresp, opBusy;
  logic [31:0] haddr, hwdata, hrdata, q;  // Bus lines, last read
  logic [1:0]  htrans;                    // Transfer kind
  logic [2:0]  hsize;
  logic        ySign;                     // Memory operand fields
  logic [7:0]  yChar;
  logic [26:0] yHi, yLo;
  logic [35:0] yWord, y1Word;             // Words from memory
  int          miscompares, n_checks;     // Report counters
  logic [8:0]  ops [3] = '{dpfa_pkg::OP_ADD_MAG, dpfa_pkg::OP_SUB,
                           dpfa_pkg::OP_SUB_MAG};  // Add family codes
  dpfa_core dut_u (.sys_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp,
    .hrdata, .opBusy);
  dpfa_mem_model mem_u (.ySign, .yChar, .yHiFrac(yHi), .yLoFrac(yLo),
    .yWord, .y1Word);
  // Free-running 40 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Verdict and end of run
  task automatic close_out;
    if (miscompares == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Compare one value
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One bus phase, ended by hready under a bound
  task automatic bus_step;
    int k;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50) begin
      miscompares++;
      close_out();
    end
  endtask
  // Single word transfer, read data left in q
  task automatic xfer(input logic w, input logic [7:0] a, logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hsize <= 3'h2;
    hwrite <= w;
    bus_step();
    htrans <= 2'h0;
    hwdata <= d;
    bus_step();
    q = hrdata;
  endtask
  // Start an operation and count its busy cycles
  task automatic run(input logic [9:0] op, output int n);
    xfer(1'b1, dpfa_pkg::ADDR_CTRL, {1'b1, 21'h0, op});
    @(posedge sys_clk);
    n = 0;
    while (opBusy === 1'b1 && n < 200) begin
      n++;
      @(posedge sys_clk);
    end
    if (n >= 200) chk("busy_bound", 32'h0, 32'h1);
    if (n >= 200) close_out();
  endtask
  // Load the implied operand and the memory pair
  task automatic load(input logic [8:0] hi, input logic [26:0] a, b);
    xfer(1'b1, dpfa_pkg::ADDR_AC_HI, 32'(hi));
    xfer(1'b1, dpfa_pkg::ADDR_AC_FR, 32'(a));
    xfer(1'b1, dpfa_pkg::ADDR_MQ_FR, 32'(b));
    xfer(1'b1, dpfa_pkg::ADDR_Y_HI, 32'(yWord[35:27]));
    xfer(1'b1, dpfa_pkg::ADDR_Y_FR, 32'(yWord[26:0]));
    xfer(1'b1, dpfa_pkg::ADDR_Y1_FR, 32'(y1Word[26:0]));
  endtask
  // Read back and compare both result words
  task automatic result(input logic [8:0] hi, mh, input logic [26:0] f, g);
    xfer(1'b0, dpfa_pkg::ADDR_AC_HI, 32'h0);
    chk("ac_hi", 32'(hi), q);
    xfer(1'b0, dpfa_pkg::ADDR_AC_FR, 32'h0);
    chk("ac_fr", 32'(f), q);
    xfer(1'b0, dpfa_pkg::ADDR_MQ_HI, 32'h0);
    chk("mq_hi", 32'(mh), q);
    xfer(1'b0, dpfa_pkg::ADDR_MQ_FR, 32'h0);
    chk("mq_fr", 32'(g), q);
  endtask
  // Expected fraction of three products; bit 54 marks a shift
  function automatic logic [54:0] prod(input logic [26:0] a, b, c, d);
    logic [53:0] r;
    r = 54'(a) * 54'(c) + ((54'(b) * 54'(c)) >> 27)
      + ((54'(a) * 54'(d)) >> 27);
    if (r[53]) return {1'b0, r};
    return {1'b1, r << 1};
  endfunction
  // Main sequence
  initial begin
    logic [54:0] p;
    logic [7:0]  ac, ch;
    logic [26:0] a, b;
    logic        s;
    int          n;
    {sys_rst, hsel, hwrite, haddr, htrans, hwdata} = {1'b1, 68'h0};
    {ySign, yChar, yHi, yLo} = 63'h0;
    void'($urandom(81));
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    xfer(1'b0, 8'h3C, 32'h0);
    chk("unmapped", 32'h0, q);
    chk("hresp", 32'h0, 32'(hresp));
    // Random normalized multiplies, plus by minus
    repeat (3) begin
      a = {1'b1, 26'($urandom)};
      b = 27'($urandom);
      ac = 8'(100 + $urandom % 70);
      {ySign, yChar, yHi, yLo} = {1'b1, 8'(100 + $urandom % 70),
        1'b1, 26'($urandom), 27'($urandom)};
      load({1'b0, ac}, a, b);
      run({1'b0, dpfa_pkg::OP_MUL}, n);
      chk("mul_len", 32'd64, 32'(n));
      p = prod(a, b, yHi, yLo);
      ch = ac + yChar - 8'h80 - 8'(p[54]);
      result({1'b1, ch}, {1'b1, ch - 8'h1B}, p[53:27], p[26:0]);
    end
    // Zero multiplier ends at execute time
    load({1'b1, 8'h90}, 27'h0, 27'h0);
    run({1'b0, dpfa_pkg::OP_MUL}, n);
    chk("zero_len", 32'd9, 32'(n));
    result(9'h000, 9'h000, 27'h0, 27'h0);
    // Characteristic overflow then underflow
    for (int i = 0; i < 2; i++) begin
      {ySign, yChar, yHi, yLo} = {1'b0, i ? 8'h0A : 8'hFA, 27'h4000000, 27'h0};
      load({1'b0, yChar}, 27'h4000000, 27'h0);
      run({1'b0, dpfa_pkg::OP_MUL}, n);
      xfer(1'b0, dpfa_pkg::ADDR_STATUS, 32'h0);
      chk("range_flag", 32'h1, 32'(q[dpfa_pkg::ST_OVF_BIT + i]));
    end
    // Minus form of multiply is refused
    run({1'b1, dpfa_pkg::OP_MUL}, n);
    xfer(1'b0, dpfa_pkg::ADDR_STATUS, 32'h0);
    chk("illegal", 32'h1, 32'(q[dpfa_pkg::ST_ILL_BIT]));
    // Add family, both forms: magnitudes sum to one
    for (int i = 0; i < 6; i++) begin
      s = (i >= 4);
      {ySign, yChar, yHi, yLo} = {1'b1, 8'h80, 27'h4000000, 27'h0};
      load({s, 8'h80}, 27'h4000000, 27'h0);
      run({i[0], ops[i / 2]}, n);
      chk("add_len", 32'h1, 32'(n <= (i[0] ? 72 : 96)));
      result({s, 8'h81}, {s, 8'h66}, 27'h4000000, 27'h0);
    end
    close_out();
  end
endmodule // dpfa_core_tb_top
